// ### design/backlight_boost_pkg.sv
package backlight_boost_pkg;
  // system clock rate
  localparam int unsigned CLK_KHZ         = 125000;
  // headroom check period
  localparam int unsigned CHECK_US        = 10;
  localparam int unsigned CHECK_CYC       = (CLK_KHZ * CHECK_US + 999) / 1000;
  // undervoltage timeout
  localparam int unsigned UVP_TIMEOUT_MS  = 100;
  localparam int unsigned UVP_TIMEOUT_CYC = CLK_KHZ * UVP_TIMEOUT_MS;
  // hold-off before a restart out of fault recovery
  localparam int unsigned RECOVERY_MS     = 100;
  localparam int unsigned RECOVERY_CYC    = CLK_KHZ * RECOVERY_MS;
  // window after reset in which sync edges are counted
  localparam int unsigned DETECT_US       = 100;
  localparam int unsigned DETECT_CYC      = (CLK_KHZ * DETECT_US + 999) / 1000;
  localparam int unsigned SYNC_EDGES_MIN  = 4;
  localparam int unsigned CNT_W           = 24;

  localparam int unsigned TGT_W           = 8;
  localparam int unsigned BRT_W           = 16;
  localparam int unsigned LED_N           = 6;
  localparam int unsigned INIT_PCT        = 90;

  // interface strap and brightness source encodings
  localparam logic        IF_I2C          = 1'b1;
  localparam logic        BRT_SRC_PWM     = 1'b0;
  localparam logic        BRT_SRC_REG     = 1'b1;
  localparam logic        BRT_SRC_RESET   = BRT_SRC_PWM;
  // the two slave addresses, values arbitrary
  localparam logic [6:0]  I2C_ADDR_LOW    = 7'h2C;
  localparam logic [6:0]  I2C_ADDR_HIGH   = 7'h2D;

  // internal boost frequencies in kHz, picked by the set-resistor code
  localparam int unsigned FREQ_KHZ [8]    = '{303, 400, 606, 800, 1000, 1250, 1667, 2200};
  localparam int unsigned DIV_W           = 10;
  localparam int unsigned SPREAD_W        = 3;

  typedef struct packed {
    logic ovpLow;
    logic ovpHigh;
    logic undervoltage_level;
    logic thermal;
  } fault_lvl_t;

  typedef struct packed {
    logic [LED_N-1:0] inUse;
    logic [LED_N-1:0] openShort;
    logic [LED_N-1:0] belowLow;
    logic [LED_N-1:0] aboveHigh;
  } led_mon_t;

  typedef enum logic [2:0] {
    ST_START   = 3'b001,
    ST_RUN     = 3'b010,
    ST_RECOVER = 3'b100
  } boost_state_t;

  // clock cycles in one boost period for a frequency code
  function automatic logic [DIV_W-1:0] boostPeriod(input logic [2:0] idx);
    boostPeriod = DIV_W'(CLK_KHZ / FREQ_KHZ[idx]);
  endfunction

  // start-up target, a fixed share of the maximum
  function automatic logic [TGT_W-1:0] initTarget(input logic [TGT_W-1:0] maxT);
    initTarget = TGT_W'((int'(maxT) * INIT_PCT + 50) / 100);
  endfunction
endpackage

// ### design/sync_clock_detect.sv
`timescale 1ns/10ps
`default_nettype none
module sync_clock_detect
  import backlight_boost_pkg::*;
#(
  parameter int unsigned WINDOW_CYC = DETECT_CYC
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic syncPin,
  output var  logic done_ff,
  output var  logic extPresent_ff,
  output var  logic staticHigh_ff
);
  logic [CNT_W-1:0] winCnt_ff;
  logic [2:0]       edgeCnt_ff;
  logic             syncPrev_ff;

  // edge counter saturates so a fast clock cannot wrap it back below the limit
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      winCnt_ff   <= '0;
      edgeCnt_ff  <= '0;
      syncPrev_ff <= 1'b0;
    end else begin
      syncPrev_ff <= syncPin;
      if (!done_ff) begin
        winCnt_ff <= winCnt_ff + 1'b1;
        // first cycle skipped: a pin tied high would otherwise look like a fresh edge
        if (syncPin && !syncPrev_ff && winCnt_ff != '0 && edgeCnt_ff != 3'h7) begin
          edgeCnt_ff <= edgeCnt_ff + 1'b1;
        end
      end
    end
  end

  // decision taken once at the end of the window and then frozen
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      done_ff       <= 1'b0;
      extPresent_ff <= 1'b0;
      staticHigh_ff <= 1'b0;
    end else if (!done_ff && winCnt_ff == CNT_W'(WINDOW_CYC - 1)) begin
      done_ff       <= 1'b1;
      extPresent_ff <= (int'(edgeCnt_ff) >= SYNC_EDGES_MIN);
      staticHigh_ff <= syncPin;
    end
  end
endmodule
`default_nettype wire

// ### design/boost_clock_gen.sv
`timescale 1ns/10ps
`default_nettype none
module boost_clock_gen
  import backlight_boost_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       extSel,
  input  wire logic       spreadEn,
  input  wire logic [2:0] freqIdx,
  input  wire logic       syncLvl,
  output var  logic       clkLvl_ff
);
  logic [DIV_W-1:0]    cnt_ff;
  logic [DIV_W-1:0]    period_ff;
  logic [SPREAD_W-1:0] lfsr_ff;
  logic [DIV_W-1:0]    nxt_period;

  // spread spectrum stretches each period by a pseudo-random few cycles
  always_comb begin
    nxt_period = boostPeriod(freqIdx);
    if (spreadEn) begin
      nxt_period = nxt_period + DIV_W'(lfsr_ff);
    end
  end

  // internal oscillator; the period is latched per cycle to keep duty clean
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff    <= '0;
      period_ff <= DIV_W'(CLK_KHZ / FREQ_KHZ[0]);
      lfsr_ff   <= 3'h1;
    end else if (cnt_ff >= period_ff - 1'b1) begin
      cnt_ff    <= '0;
      period_ff <= nxt_period;
      lfsr_ff   <= {lfsr_ff[1:0], lfsr_ff[2] ^ lfsr_ff[1]};
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  // external sync wins once it was seen at start-up
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clkLvl_ff <= 1'b0;
    end else begin
      clkLvl_ff <= extSel ? syncLvl : (cnt_ff < (period_ff >> 1));
    end
  end
endmodule
`default_nettype wire

// ### design/backlight_boost_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module backlight_boost_ctrl
  import backlight_boost_pkg::*;
#(
  parameter int unsigned UVP_CYC     = UVP_TIMEOUT_CYC,
  parameter int unsigned RECOVER_CYC = RECOVERY_CYC,
  parameter int unsigned DETECT_WIN  = DETECT_CYC
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             ifSelStrap,
  input  wire logic             slave_address_select_pin,
  input  wire logic [BRT_W-1:0] pwmDuty,
  input  wire logic [BRT_W-1:0] display_brightness_value,
  input  wire logic             brtSrcWrEn,
  input  wire logic             brtSrcWrData,
  input  wire logic             boost_sync_clock_pin,
  input  wire logic [2:0]       boost_frequency_set_pin,
  input  wire logic [TGT_W-1:0] targetMin,
  input  wire logic [TGT_W-1:0] targetMax,
  input  wire logic             ledDriversActive,
  input  wire led_mon_t         ledMon,
  input  wire fault_lvl_t       faultLvl,
  input  wire logic [2:0]       flagClear,
  input  wire logic             supplyFall,
  output var  logic             i2cSel_ff,
  output var  logic [6:0]       slaveAddr_ff,
  output var  logic             brightness_source_select,
  output var  logic [BRT_W-1:0] brightness_ff,
  output var  logic             extClkSel_ff,
  output var  logic             spreadEn_ff,
  output var  logic             boostGate_ff,
  output var  logic [TGT_W-1:0] target_ff,
  output var  logic             overvoltage_low_flag,
  output var  logic             overvoltage_high_flag,
  output var  logic             boost_overcurrent_flag,
  output var  logic             faultOut_ff,
  output var  logic             faultOe_n_ff
);
  boost_state_t     state_ff;
  logic             strapDone_ff;
  logic             brtSrc_ff;
  logic [LED_N-1:0] excluded_ff;
  logic [CNT_W-1:0] checkCnt_ff;
  logic             checkTick;
  logic [CNT_W-1:0] uvpCnt_ff;
  logic             uvpTimeout;
  logic [CNT_W-1:0] recCnt_ff;
  logic             ovpLowFlag_ff;
  logic             ovpHighFlag_ff;
  logic             ocpFlag_ff;
  logic [LED_N-1:0] watched;
  logic             anyLow;
  logic             allHigh;
  logic             detDone;
  logic             detExt;
  logic             detHigh;
  logic             clkLvl;

  assign brightness_source_select = brtSrc_ff;
  assign overvoltage_low_flag     = ovpLowFlag_ff;
  assign overvoltage_high_flag    = ovpHighFlag_ff;
  assign boost_overcurrent_flag   = ocpFlag_ff;

  sync_clock_detect #(
    .WINDOW_CYC (DETECT_WIN)
  ) u_detect (
    .clk_sys       (clk_sys),
    .rst_n         (rst_n),
    .syncPin       (boost_sync_clock_pin),
    .done_ff       (detDone),
    .extPresent_ff (detExt),
    .staticHigh_ff (detHigh)
  );

  boost_clock_gen u_clkgen (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .extSel    (extClkSel_ff),
    .spreadEn  (spreadEn_ff),
    .freqIdx   (boost_frequency_set_pin),
    .syncLvl   (boost_sync_clock_pin),
    .clkLvl_ff (clkLvl)
  );

  // straps are caught on the first clock after reset release, never by the reset itself
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      strapDone_ff <= 1'b0;
      i2cSel_ff    <= 1'b0;
      slaveAddr_ff <= I2C_ADDR_LOW;
    end else if (!strapDone_ff) begin
      strapDone_ff <= 1'b1;
      i2cSel_ff    <= (ifSelStrap == IF_I2C);
      slaveAddr_ff <= slave_address_select_pin ? I2C_ADDR_HIGH : I2C_ADDR_LOW;
    end
  end

  // source select defaults to the PWM pin so an I2C-strapped board without a host still lights
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      brtSrc_ff <= BRT_SRC_RESET;
    end else if (brtSrcWrEn) begin
      brtSrc_ff <= brtSrcWrData;
    end
  end

  // brightness mux; SPI ignores the PWM pin entirely
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      brightness_ff <= '0;
    end else if (!i2cSel_ff) begin
      brightness_ff <= display_brightness_value;
    end else if (brtSrc_ff == BRT_SRC_REG) begin
      brightness_ff <= display_brightness_value;
    end else begin
      brightness_ff <= pwmDuty;
    end
  end

  // clock mode frozen from the start-up detection
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      extClkSel_ff <= 1'b0;
      spreadEn_ff  <= 1'b0;
    end else if (detDone) begin
      extClkSel_ff <= detExt;
      spreadEn_ff  <= !detExt && detHigh;
    end
  end

  // monitored set: in use and never faulted
  assign watched = ledMon.inUse & ~excluded_ff;
  assign anyLow  = |(watched & ledMon.belowLow);
  assign allHigh = (watched != '0) && ((watched & ~ledMon.aboveHigh) == '0);

  // exclusion is sticky until reset; a flapping string must not re-enter the loop
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      excluded_ff <= '0;
    end else begin
      excluded_ff <= excluded_ff | ledMon.openShort;
    end
  end

  // periodic check tick
  assign checkTick = (checkCnt_ff == CNT_W'(CHECK_CYC - 1));
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      checkCnt_ff <= '0;
    end else if (checkTick) begin
      checkCnt_ff <= '0;
    end else begin
      checkCnt_ff <= checkCnt_ff + 1'b1;
    end
  end

  // undervoltage timeout only runs while the converter is meant to regulate
  assign uvpTimeout = (uvpCnt_ff == CNT_W'(UVP_CYC - 1));
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      uvpCnt_ff <= '0;
    end else if (!faultLvl.undervoltage_level || state_ff == ST_RECOVER) begin
      uvpCnt_ff <= '0;
    end else if (!uvpTimeout) begin
      uvpCnt_ff <= uvpCnt_ff + 1'b1;
    end
  end

  // recovery hold-off counter
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      recCnt_ff <= '0;
    end else if (state_ff == ST_RECOVER) begin
      recCnt_ff <= recCnt_ff + 1'b1;
    end else begin
      recCnt_ff <= '0;
    end
  end

  // converter sequencing
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_START;
    end else begin
      unique case (state_ff)
        ST_START: begin
          if (faultLvl.ovpHigh || uvpTimeout) begin
            state_ff <= ST_RECOVER;
          end else if (ledDriversActive) begin
            state_ff <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (faultLvl.ovpHigh || uvpTimeout) begin
            state_ff <= ST_RECOVER;
          end
        end
        ST_RECOVER: begin
          if (recCnt_ff == CNT_W'(RECOVER_CYC - 1)) begin
            state_ff <= ST_START;
          end
        end
        default: state_ff <= ST_START;
      endcase
    end
  end

  // target: preset at start, one clamped step per check while running
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      target_ff <= '0;
    end else if (state_ff != ST_RUN) begin
      target_ff <= initTarget(targetMax);
    end else if (checkTick && anyLow) begin
      target_ff <= (target_ff < targetMax) ? target_ff + 1'b1 : targetMax;
    end else if (checkTick && allHigh) begin
      target_ff <= (target_ff > targetMin) ? target_ff - 1'b1 : targetMin;
    end
  end

  // gate stops under low overvoltage and recovers on its own when the level drops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      boostGate_ff <= 1'b0;
    end else begin
      boostGate_ff <= clkLvl && detDone && !faultLvl.ovpLow
                      && state_ff != ST_RECOVER;
    end
  end

  // sticky flags; a new event wins over a clear in the same cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ovpLowFlag_ff  <= 1'b0;
      ovpHighFlag_ff <= 1'b0;
      ocpFlag_ff     <= 1'b0;
    end else begin
      ovpLowFlag_ff  <= faultLvl.ovpLow || (ovpLowFlag_ff && !flagClear[0] && !supplyFall);
      ovpHighFlag_ff <= faultLvl.ovpHigh || (ovpHighFlag_ff && !flagClear[1] && !supplyFall);
      ocpFlag_ff     <= uvpTimeout || (ocpFlag_ff && !flagClear[2] && !supplyFall);
    end
  end

  // open-drain pin: data held low, enable low means pulling
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      faultOut_ff  <= 1'b0;
      faultOe_n_ff <= 1'b1;
    end else begin
      faultOut_ff  <= 1'b0;
      faultOe_n_ff <= !(ovpLowFlag_ff || ovpHighFlag_ff || ocpFlag_ff
                        || faultLvl.thermal || (excluded_ff != '0));
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  AST_SPI_BRIGHTNESS: assert property (strapDone_ff && !i2cSel_ff
    |=> brightness_ff == $past(display_brightness_value))
    else $error("spi brightness not from register");
  AST_BRT_SRC_HOLD: assert property (!brtSrcWrEn |=> $stable(brtSrc_ff))
    else $error("brightness source moved without a write");
  AST_STRAP_FROZEN: assert property (strapDone_ff |=> $stable(i2cSel_ff) && $stable(slaveAddr_ff))
    else $error("strap result changed after capture");
  AST_SPREAD_EXT: assert property (extClkSel_ff |-> !spreadEn_ff)
    else $error("spread spectrum with external clock");
  AST_GATE_OVPL: assert property (faultLvl.ovpLow |=> !boostGate_ff && ovpLowFlag_ff)
    else $error("gate active under low overvoltage");
  AST_OVPH_RECOVER: assert property ((state_ff != ST_RECOVER) && faultLvl.ovpHigh
    |=> state_ff == ST_RECOVER && ovpHighFlag_ff)
    else $error("high overvoltage not handled");
  AST_UVP_OCP: assert property (uvpTimeout && state_ff != ST_RECOVER
    |=> state_ff == ST_RECOVER && ocpFlag_ff)
    else $error("undervoltage timeout not handled");
  AST_TARGET_STEP: assert property (state_ff == ST_RUN && $past(state_ff) == ST_RUN
    |-> (target_ff - $past(target_ff) <= TGT_W'(1)) || ($past(target_ff) - target_ff <= TGT_W'(1))
        || !$stable(targetMax) || !$stable(targetMin))
    else $error("target moved more than one step");
  AST_TARGET_RAISE: assert property (state_ff == ST_RUN && checkTick && anyLow
    && target_ff < targetMax && ledDriversActive && !faultLvl.ovpHigh && !uvpTimeout
    |=> target_ff == $past(target_ff) + 1'b1)
    else $error("target not raised on low headroom");
  AST_TARGET_HOLD: assert property (state_ff == ST_RUN && !checkTick
    && !faultLvl.ovpHigh && !uvpTimeout |=> $stable(target_ff))
    else $error("target moved between checks");
  AST_FLAG_STICKY: assert property (ocpFlag_ff && !flagClear[2] && !supplyFall |=> ocpFlag_ff)
    else $error("overcurrent flag dropped without clear");
  AST_FAULT_PIN: assert property (ovpHighFlag_ff |=> !faultOe_n_ff)
    else $error("fault pin released with flag set");
  AST_EXCLUDE: assert property (ledMon.openShort[0] |=> excluded_ff[0] [*3])
    else $error("faulted string came back into the loop");

  COV_RUN: cover property (state_ff == ST_START ##1 state_ff == ST_RUN);
  COV_RECOVER: cover property (state_ff == ST_RECOVER ##1 state_ff == ST_START);
  COV_RAISE: cover property (state_ff == ST_RUN && checkTick && anyLow);
  COV_CLEAR: cover property (ovpLowFlag_ff ##1 !ovpLowFlag_ff);
endmodule
`default_nettype wire

// ### verif/host_model.sv
`timescale 1ns/10ps
`default_nettype none
// host side of the control port: one-cycle requests become register pulses
module host_model (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [2:0]  clrReq,
  input  wire logic        fallReq,
  input  wire logic        srcReq,
  input  wire logic        srcBit,
  input  wire logic [15:0] regVal,
  output var  logic [2:0]  flagClear_ff,
  output var  logic        supplyFall_ff,
  output var  logic        srcWrEn_ff,
  output var  logic        srcWrData_ff,
  output var  logic [15:0] regVal_ff
);
  // flag service: clear and supply-fall requests are registered as given, with no look at the faults
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flagClear_ff  <= 3'h0;
      supplyFall_ff <= 1'b0;
    end else begin
      flagClear_ff  <= clrReq;
      supplyFall_ff <= fallReq;
    end
  end
  // host owns the brightness registers; data is junk outside a write
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      srcWrEn_ff   <= 1'b0;
      srcWrData_ff <= 1'b0;
      regVal_ff    <= 16'h0000;
    end else begin
      srcWrEn_ff   <= srcReq;
      srcWrData_ff <= srcReq ? srcBit : ~srcWrData_ff; // no stale value
      regVal_ff    <= regVal;
    end
  end
endmodule
`default_nettype wire

// ### verif/tb_backlight_boost_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module tb_backlight_boost_ctrl;
  import backlight_boost_pkg::*;
  localparam int         UNDERVOLTAGE_LEVEL  = 50;
  localparam int         REC  = 20;
  localparam int         WIN  = 64;
  localparam int         TMAX = 100;
  localparam logic [7:0] INIT = 8'((TMAX * INIT_PCT + 50) / 100);
  logic        clk_sys = 1'b0, rst_n = 1'b0, ifSel = 1'b0, addrPin = 1'b0;
  logic        syncLvl = 1'b0, syncTgl = 1'b0, sync = 1'b0, ledAct = 1'b0;
  logic        fallReq = 1'b0, srcReq = 1'b0, srcBit = 1'b0;
  logic [2:0]  freq = 3'h7, clrReq = 3'h0;
  logic [15:0] pwmDuty = 16'h0000, regVal = 16'h0000, bE = 16'h0000;
  led_mon_t    ledMon = '0;
  fault_lvl_t  fLvl = '0;
  logic [27:0] expQ[$];
  logic [27:0] prevObs, obs;
  int          fail_count = 0, compares = 0;
  integer      seed;
  wire logic [2:0]  flagClear_ff;
  wire logic [15:0] regVal_ff, brightness_ff;
  wire logic [7:0]  target_ff;
  wire logic [6:0]  slaveAddr_ff;
  wire logic        supplyFall_ff, srcWrEn_ff, srcWrData_ff, i2cSel_ff, brtSrc, extClkSel_ff;
  wire logic        spreadEn_ff, boostGate_ff, ovl, ovh, ocp, faultOe_n_ff, faultOut;

  host_model host_model_inst (.clk_sys(clk_sys), .rst_n(rst_n), .clrReq(clrReq), .fallReq(fallReq),
    .srcReq(srcReq), .srcBit(srcBit), .regVal(regVal), .flagClear_ff(flagClear_ff),
    .supplyFall_ff(supplyFall_ff), .srcWrEn_ff(srcWrEn_ff), .srcWrData_ff(srcWrData_ff),
    .regVal_ff(regVal_ff));
  backlight_boost_ctrl #(.UVP_CYC(UNDERVOLTAGE_LEVEL), .RECOVER_CYC(REC), .DETECT_WIN(WIN)) backlight_boost_ctrl_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .ifSelStrap(ifSel), .slave_address_select_pin(addrPin),
    .pwmDuty(pwmDuty), .display_brightness_value(regVal_ff), .brtSrcWrEn(srcWrEn_ff),
    .brtSrcWrData(srcWrData_ff), .boost_sync_clock_pin(sync), .boost_frequency_set_pin(freq),
    .targetMin(INIT - 8'h01), .targetMax(8'(TMAX)), .ledDriversActive(ledAct), .ledMon(ledMon),
    .faultLvl(fLvl), .flagClear(flagClear_ff), .supplyFall(supplyFall_ff), .i2cSel_ff(i2cSel_ff),
    .slaveAddr_ff(slaveAddr_ff), .brightness_source_select(brtSrc), .brightness_ff(brightness_ff),
    .extClkSel_ff(extClkSel_ff), .spreadEn_ff(spreadEn_ff), .boostGate_ff(boostGate_ff),
    .target_ff(target_ff), .overvoltage_low_flag(ovl), .overvoltage_high_flag(ovh),
    .boost_overcurrent_flag(ocp), .faultOut_ff(faultOut), .faultOe_n_ff(faultOe_n_ff));

  always #4 clk_sys = ~clk_sys;
  // sync pin: a static strap level, or a toggle that looks like an external clock
  always @(posedge clk_sys) sync <= syncTgl ? ~sync : syncLvl;
  assign obs = {brightness_ff, target_ff, ovl, ovh, ocp, faultOe_n_ff};

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // every change of the watched outputs out of reset is matched against the oldest note, and fails if none is left
  always @(negedge clk_sys) begin
    if (rst_n && obs !== prevObs) begin
      if (expQ.size() == 0) cmp("unexpected change", prevObs, obs);
      else cmp("watched outputs", expQ.pop_front(), obs);
    end
    prevObs = obs;
  end
  task automatic finish_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic note(input logic [7:0] t, input logic [3:0] f);
    expQ.push_back({bE, t, f});
  endtask
  // wait for the notes to be used up, bounded
  task automatic drain(input int n);
    for (int i = 0; i < n && expQ.size() > 0; i++) tick(1);
    cmp("pending notes", 0, expQ.size());
  endtask
  task automatic host(input logic [2:0] c, input logic f, input logic s);
    clrReq = c;
    fallReq = f;
    srcReq = s;
    tick(1);
    clrReq = 3'h0;
    fallReq = 1'b0;
    srcReq = 1'b0;
  endtask
  task automatic waitRise(output int n);
    logic p;
    p = boostGate_ff;
    n = 0;
    do begin
      tick(1);
      n++;
      if (boostGate_ff === 1'b1 && p === 1'b0) break;
      p = boostGate_ff;
    end while (n < 1000);
  endtask
  // the gate must stay off for n cycles
  task automatic quiet(input int n);
    int h;
    h = 0;
    repeat (n) begin
      tick(1);
      if (boostGate_ff !== 1'b0) h++;
    end
    cmp("gate while stopped", 0, h);
  endtask
  task automatic doReset(input logic i, input logic a, input logic s, input logic t);
    rst_n = 1'b0;
    {ifSel, addrPin, syncLvl, syncTgl, ledAct} = {i, a, s, t, 1'b0};
    {pwmDuty, regVal, bE} = '0;
    ledMon = '0;
    fLvl = '0;
    tick(10);
    expQ.delete();
    note(INIT, 4'h1);
    rst_n = 1'b1;
    tick(1);
    cmp("interface", i, i2cSel_ff);
    cmp("address", a ? I2C_ADDR_HIGH : I2C_ADDR_LOW, slaveAddr_ff);
    cmp("source at reset", BRT_SRC_RESET, brtSrc);
    tick(WIN + 4);
  endtask

  initial begin
    int n;
    seed = 32'h5b1f_271b;
    doReset(1'b0, 1'b0, 1'b0, 1'b0);
    cmp("external clock", 1'b0, extClkSel_ff);
    cmp("spread", 1'b0, spreadEn_ff);
    regVal = 16'($random(seed));
    bE = regVal;
    note(INIT, 4'h1);
    drain(10);
    pwmDuty = 16'($random(seed)); // ignored under the serial-peripheral host
    tick(5);
    for (int i = 0; i < 8; i++) begin
      freq = 3'(i);
      repeat (3) waitRise(n);
      cmp("boost period", CLK_KHZ / FREQ_KHZ[i], n);
    end
    fLvl.ovpLow = 1'b1;
    note(INIT, 4'h9);
    note(INIT, 4'h8);
    drain(10);
    quiet(100);
    cmp("fault pin data", 1'b0, faultOut);
    host(3'h1, 1'b0, 1'b0);
    tick(5);
    fLvl.ovpLow = 1'b0;
    waitRise(n);
    cmp("restart", 1'b1, n < 100);
    note(INIT, 4'h0);
    note(INIT, 4'h1);
    host(3'h1, 1'b0, 1'b0);
    drain(10);
    note(INIT, 4'h5);
    note(INIT, 4'h4);
    fLvl.ovpHigh = 1'b1;
    tick(1);
    fLvl.ovpHigh = 1'b0;
    drain(10);
    tick(2);
    quiet(REC - 8);
    note(INIT, 4'h0);
    note(INIT, 4'h1);
    host(3'h0, 1'b1, 1'b0);
    drain(10);
    tick(REC + 10);
    fLvl.undervoltage_level = 1'b1;
    tick(UNDERVOLTAGE_LEVEL - 20);
    fLvl.undervoltage_level = 1'b0; // back in time, so nothing is flagged
    tick(10);
    fLvl.undervoltage_level = 1'b1;
    tick(UNDERVOLTAGE_LEVEL - 3);
    cmp("overcurrent early", 1'b0, ocp);
    note(INIT, 4'h3);
    note(INIT, 4'h2);
    drain(10);
    fLvl.undervoltage_level = 1'b0;
    note(INIT, 4'h0);
    note(INIT, 4'h1);
    host(3'h4, 1'b0, 1'b0);
    drain(10);
    tick(REC + 10);
    note(INIT, 4'h0);
    fLvl.thermal = 1'b1;
    drain(10);
    note(INIT, 4'h1);
    fLvl.thermal = 1'b0;
    drain(10);
    doReset(1'b1, 1'b1, 1'b1, 1'b0);
    cmp("spread", 1'b1, spreadEn_ff);
    pwmDuty = 16'($random(seed));
    bE = pwmDuty;
    note(INIT, 4'h1);
    drain(10);
    regVal = 16'($random(seed));
    tick(5);
    bE = regVal;
    note(INIT, 4'h1);
    srcBit = 1'b1;
    host(3'h0, 1'b0, 1'b1);
    drain(10);
    cmp("source", BRT_SRC_REG, brtSrc);
    ledMon.inUse = 6'h3F;
    ledAct = 1'b1;
    ledMon.belowLow = 6'h01;
    note(INIT + 8'h01, 4'h1);
    drain(1300);
    ledMon.belowLow = 6'h00;
    ledMon.aboveHigh = 6'h3E;
    tick(1300);
    ledMon.aboveHigh = 6'h3F;
    note(INIT, 4'h1);
    note(INIT - 8'h01, 4'h1);
    drain(2600);
    tick(1300);
    ledMon.aboveHigh = 6'h00;
    ledMon.inUse = 6'h3E;
    ledMon.belowLow = 6'h01;
    tick(1300);
    ledMon.inUse = 6'h3F;
    ledMon.belowLow = 6'h00;
    ledMon.openShort = 6'h01;
    note(INIT - 8'h01, 4'h0);
    tick(1);
    ledMon.openShort = 6'h00;
    tick(2);
    ledMon.belowLow = 6'h01;
    tick(1300);
    ledMon.belowLow = 6'h03;
    note(INIT, 4'h0);
    drain(1300);
    // hand brightness back to the PWM pin
    bE = pwmDuty;
    note(INIT, 4'h0);
    srcBit = 1'b0;
    host(3'h0, 1'b0, 1'b1);
    drain(10);
    cmp("source back", BRT_SRC_PWM, brtSrc);
    doReset(1'b0, 1'b0, 1'b0, 1'b1);
    cmp("external clock", 1'b1, extClkSel_ff);
    cmp("spread with sync", 1'b0, spreadEn_ff);
    finish_test();
  end
  // hang guard: the run needs about 15k cycles
  initial begin
    #(8 * 40000);
    fail_count++;
    finish_test();
  end
endmodule
`default_nettype wire
